//--- verilog/mmb_regs.svh
// Constants for the memory map and bank decode block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef MMB_REGS_SVH
`define MMB_REGS_SVH

`define MMB_PC_W 13
`define MMB_INSTR_W 14
`define MMB_RESET_VECTOR 13'h0000
`define MMB_IRQ_VECTOR 13'h0004
`define MMB_BANK_HI_BIT 6
`define MMB_BANK_LO_BIT 5
`define MMB_IRP_BIT 7
`define MMB_BANK_TOP 7'h7F
`define MMB_SFR_END_LOW 7'h20
`define MMB_SFR_END_HIGH 7'h10
`define MMB_COMMON_BASE 7'h70
`define MMB_OFS_INDIRECT 7'h00
`define MMB_OFS_PC_LOW 7'h02
`define MMB_OFS_STATUS 7'h03
`define MMB_OFS_POINTER 7'h04
`define MMB_OFS_PC_LATCH 7'h0A
`define MMB_STATUS_RST 8'h00
`define MMB_POINTER_RST 8'h00
`define MMB_PC_LATCH_RST 8'h00
`define MMB_RAM_DEPTH 512

`endif

//--- verilog/mmb_pkg.sv
// Types for the memory map and bank decode block.
// Assumes mmb_regs.svh is compiled with it.
`default_nettype none
package mmb_pkg;
    typedef logic [12:0] mmb_pc_t;
    typedef logic [8:0] mmb_daddr_t;
    typedef logic [7:0] mmb_byte_t;
    typedef enum logic [1:0] {
        MMB_REG_SFR = 2'b00,
        MMB_REG_GPR = 2'b01,
        MMB_REG_NONE = 2'b10
    } mmb_region_t;
endpackage : mmb_pkg
`default_nettype wire

//--- verilog/mmb_gpr_ram.sv
// General-purpose static RAM of the data space, held in flip-flops.
// Assumes the caller folds mirrored addresses before indexing.
`default_nettype none
`include "mmb_regs.svh"
module mmb_gpr_ram (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire mmb_pkg::mmb_daddr_t addr,
    input wire mmb_pkg::mmb_byte_t wdata,
    output mmb_pkg::mmb_byte_t rdata
);
    import mmb_pkg::*;

    mmb_byte_t mem_q [`MMB_RAM_DEPTH];

    genvar i;
    generate
        for (i = 0; i < `MMB_RAM_DEPTH; i++) begin : g_byte
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mem_q[i] <= 8'h00;
                end else if (we && addr == 9'(i)) begin
                    mem_q[i] <= wdata;
                end
            end
        end
    endgenerate

    // Combinational read so the top can register one merged result
    assign rdata = mem_q[addr];
endmodule : mmb_gpr_ram
`default_nettype wire

//--- verilog/mmb_memory_map.sv
// Program counter, program fetch port and banked data decode of the core.
// Assumes the core drives requests synchronous to clk; no bus master.
//
// What this block does
// - Program counter is 13 bits, spanning up to 8K words of 14 bits.
// - Implemented flash is 8K or 4K words, chosen by build parameter.
// - Addresses above implemented flash wrap by dropping upper bits.
// - Every reset loads the program counter with 0000h.
// - A taken interrupt sends the program counter to 0004h.
// - Status bits 6 and 5 select data bank 0 to 3.
// - Each bank spans 128 bytes, offsets 00h to 7Fh.
// - Low bank offsets decode to special registers, higher ones to RAM.
// - Mirrored special registers reach one physical register from any bank.
// - Fetch and data access use separate buses in the same cycle.
// - Data is reached by direct offset or through the file select pointer.
`default_nettype none
`include "mmb_regs.svh"
module mmb_memory_map #(
    parameter int FLASH_ADDR_W = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pc_step,
    input wire logic pc_jump,
    input wire mmb_pkg::mmb_pc_t pc_jump_addr,
    input wire logic irq_take,
    input wire logic [`MMB_INSTR_W-1:0] prog_rdata,
    input wire logic data_req,
    input wire logic data_we,
    input wire logic [6:0] data_offset,
    input wire mmb_pkg::mmb_byte_t data_wdata,
    output mmb_pkg::mmb_pc_t pc_q,
    output logic [`MMB_INSTR_W-1:0] instr_q,
    output mmb_pkg::mmb_byte_t data_rdata_q,
    output mmb_pkg::mmb_daddr_t data_addr_q,
    output logic data_sfr_q,
    output logic data_valid_q,
    output mmb_pkg::mmb_byte_t status_q,
    output mmb_pkg::mmb_byte_t file_select_pointer_q
);
    import mmb_pkg::*;

    localparam mmb_pc_t FLASH_MASK = mmb_pc_t'((1 << FLASH_ADDR_W) - 1);

    mmb_byte_t pc_latch_q;
    mmb_daddr_t eff_addr;
    mmb_daddr_t ram_addr;
    mmb_region_t region;
    mmb_byte_t ram_rdata;
    mmb_byte_t sfr_rdata;
    logic [1:0] bank_sel;
    logic bank_select_high;
    logic bank_select_low;
    logic indirect;
    logic sfr_wr;
    logic ram_we;

    // Region decode, used for both the read path and the write strobes
    function automatic mmb_region_t decode(input mmb_daddr_t a);
        logic [6:0] ofs;
        logic [6:0] sfr_end;
        ofs = a[6:0];
        sfr_end = (a[8] == 1'b0) ? `MMB_SFR_END_LOW : `MMB_SFR_END_HIGH;
        if (ofs == `MMB_OFS_INDIRECT) begin
            decode = MMB_REG_NONE;
        end else if (ofs < sfr_end) begin
            decode = MMB_REG_SFR;
        end else begin
            decode = MMB_REG_GPR;
        end
    endfunction : decode

    // True for the special registers that answer in every bank
    function automatic logic is_reg(input mmb_daddr_t a, input logic [6:0] o);
        is_reg = decode(a) == MMB_REG_SFR && a[6:0] == o;
    endfunction : is_reg

    // Bank select from status bits 6 and 5
    assign bank_select_high = status_q[`MMB_BANK_HI_BIT];
    assign bank_select_low = status_q[`MMB_BANK_LO_BIT];
    assign bank_sel = {bank_select_high, bank_select_low};

    // Offset zero means go through the pointer
    assign indirect = data_offset == `MMB_OFS_INDIRECT;

    always_comb begin
        if (indirect) begin
            eff_addr = {status_q[`MMB_IRP_BIT], file_select_pointer_q};
        end else begin
            eff_addr = {bank_sel, data_offset};
        end
    end

    // Region of the 9-bit data address: special register, RAM or none
    assign region = decode(eff_addr);

    // Upper 16 bytes of every bank share bank 0 storage
    always_comb begin
        if (eff_addr[6:0] >= `MMB_COMMON_BASE) begin
            ram_addr = {2'b00, eff_addr[6:0]};
        end else begin
            ram_addr = eff_addr;
        end
    end

    // Write strobes share the read decode
    assign ram_we = data_req && data_we && region == MMB_REG_GPR;
    assign sfr_wr = data_req && data_we && region == MMB_REG_SFR;

    // Static RAM above the special registers
    mmb_gpr_ram i_mmb_gpr_ram (
        .clk(clk),
        .rst(rst),
        .we(ram_we),
        .addr(ram_addr),
        .wdata(data_wdata),
        .rdata(ram_rdata)
    );

    // Mirrored registers ignore the bank bits
    always_comb begin
        // Unimplemented special offsets read zero
        sfr_rdata = 8'h00;
        if (is_reg(eff_addr, `MMB_OFS_PC_LOW)) begin
            sfr_rdata = pc_q[7:0];
        end else if (is_reg(eff_addr, `MMB_OFS_STATUS)) begin
            sfr_rdata = status_q;
        end else if (is_reg(eff_addr, `MMB_OFS_POINTER)) begin
            sfr_rdata = file_select_pointer_q;
        end else if (is_reg(eff_addr, `MMB_OFS_PC_LATCH)) begin
            sfr_rdata = pc_latch_q;
        end
    end

    // One physical status register behind every alias
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= `MMB_STATUS_RST;
        end else if (sfr_wr && is_reg(eff_addr, `MMB_OFS_STATUS)) begin
            status_q <= data_wdata;
        end
    end

    // Pointer register, writable from any bank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_select_pointer_q <= `MMB_POINTER_RST;
        end else if (sfr_wr && is_reg(eff_addr, `MMB_OFS_POINTER)) begin
            file_select_pointer_q <= data_wdata;
        end
    end

    // Upper pc bits wait here; only five of them reach the pc
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_latch_q <= `MMB_PC_LATCH_RST;
        end else if (sfr_wr && is_reg(eff_addr, `MMB_OFS_PC_LATCH)) begin
            pc_latch_q <= data_wdata;
        end
    end

    // Program counter; interrupt outranks a computed jump or step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= `MMB_RESET_VECTOR;
        end else if (irq_take) begin
            pc_q <= `MMB_IRQ_VECTOR;
        end else if (sfr_wr && is_reg(eff_addr, `MMB_OFS_PC_LOW)) begin
            // Writing the low byte also wraps
            pc_q <= {pc_latch_q[4:0], data_wdata} & FLASH_MASK;
        end else if (pc_jump) begin
            pc_q <= pc_jump_addr & FLASH_MASK;
        end else if (pc_step) begin
            // 13-bit count; wraps at flash top
            pc_q <= mmb_pc_t'(pc_q + 13'h0001) & FLASH_MASK;
        end
    end

    // Fetch register runs beside the data path every cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_q <= 14'h0000;
        end else begin
            instr_q <= prog_rdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_valid_q <= 1'b0;
        end else begin
            data_valid_q <= data_req;
        end
    end

    // Registered answer; pointer through itself reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_rdata_q <= 8'h00;
            data_addr_q <= 9'h000;
            data_sfr_q <= 1'b0;
        end else begin
            if (data_req) begin
                data_addr_q <= eff_addr;
                data_sfr_q <= region == MMB_REG_SFR;
                case (region)
                    MMB_REG_SFR: data_rdata_q <= sfr_rdata;
                    MMB_REG_GPR: data_rdata_q <= ram_rdata;
                    default: data_rdata_q <= 8'h00;
                endcase
            end
        end
    end
endmodule : mmb_memory_map
`default_nettype wire

//--- sim/mmb_chk.sv
// Checker for the memory map block, bound to its ports.
// Assumes a single clock and rst active high.
`default_nettype none
module mmb_chk #(
    parameter int FLASH_ADDR_W = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pc_step,
    input wire logic pc_jump,
    input wire mmb_pkg::mmb_pc_t pc_jump_addr,
    input wire logic irq_take,
    input wire logic data_req,
    input wire logic [6:0] data_offset,
    input wire mmb_pkg::mmb_pc_t pc_q,
    input wire mmb_pkg::mmb_daddr_t data_addr_q,
    input wire logic data_sfr_q,
    input wire logic data_valid_q,
    input wire mmb_pkg::mmb_byte_t status_q,
    input wire mmb_pkg::mmb_byte_t file_select_pointer_q
);
    timeunit 1ns;
    timeprecision 1ns;
    import mmb_pkg::*;
    localparam int PM = (1 << FLASH_ADDR_W) - 1;
    logic quiet;
    // A data write may hit the pc low byte, so the step, jump and hold checks skip any access
    assign quiet = !data_req && !irq_take;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_irq_vector: assert property (irq_take |=> pc_q == 13'h0004)
        else $error("irq vector missed");
    a_pc_step: assert property (quiet && !pc_jump && pc_step
        |=> pc_q == 13'(($past(pc_q) + 1) & PM)) else $error("bad step");
    a_pc_jump: assert property (quiet && pc_jump
        |=> pc_q == 13'($past(pc_jump_addr) & PM)) else $error("bad jump");
    a_pc_hold: assert property (quiet && !pc_jump && !pc_step
        |=> $stable(pc_q)) else $error("pc moved");
    a_valid_pulse: assert property (data_valid_q == $past(data_req))
        else $error("valid not one cycle after request");
    a_direct_addr: assert property (data_req
        && data_offset inside {[7'h01:7'h6F]} |=> data_addr_q
        == {$past(status_q[6:5]), $past(data_offset)}) else $error("dir");
    a_indirect_addr: assert property (data_req
        && data_offset == 7'h00
        |=> data_addr_q == {$past(status_q[7]),
        $past(file_select_pointer_q)}) else $error("indirect address");
    a_sfr_decode: assert property (data_req
        && data_offset inside {[7'h01:7'h0F]} |=> data_sfr_q)
        else $error("special space missed");
    a_gpr_decode: assert property (data_req
        && data_offset inside {[7'h20:7'h7F]} |=> !data_sfr_q)
        else $error("ram space decoded as special");
endmodule : mmb_chk
`default_nettype wire

//--- sim/mmb_memory_map_tb.sv
// Self-checking bench for the memory map block, 4K flash variant.
// Assumes package, design and checker are compiled first.
`default_nettype none
module mmb_memory_map_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mmb_pkg::*;
    logic clk, rst, pc_step, pc_jump, irq_take, data_req, data_we;
    logic data_sfr_q, data_valid_q;
    logic [6:0] data_offset;
    logic [13:0] prog_rdata, instr_q;
    mmb_pc_t pc_jump_addr, pc_q;
    mmb_byte_t data_wdata, data_rdata_q, status_q, file_select_pointer_q;
    mmb_daddr_t data_addr_q;
    int n_mismatch, n_tests;
    mmb_memory_map #(.FLASH_ADDR_W(12)) i_mmb_memory_map (.clk, .rst,
        .pc_step, .pc_jump, .pc_jump_addr, .irq_take, .prog_rdata,
        .data_req, .data_we, .data_offset, .data_wdata, .pc_q, .instr_q,
        .data_rdata_q, .data_addr_q, .data_sfr_q, .data_valid_q,
        .status_q, .file_select_pointer_q);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Fetch word follows the data offset of each access, so both buses run together.
    // The request stays up between back-to-back accesses; idle drops it.
    task automatic acc(input logic we, input logic [6:0] ofs,
            input mmb_byte_t wd);
        data_req = 1'b1;
        data_we = we;
        data_offset = ofs;
        data_wdata = wd;
        prog_rdata = {7'h2A, ofs};
        @(negedge clk);
        chk(data_valid_q, 16'h0001);
        chk(instr_q, {9'h02A, ofs});
    endtask : acc
    task automatic idle;
        data_req = 1'b0;
        data_we = 1'b0;
        @(negedge clk);
        chk(data_valid_q, 16'h0000);
    endtask : idle
    task automatic rd(input logic [6:0] ofs, input mmb_byte_t exp);
        acc(1'b0, ofs, 8'h00);
        chk(data_rdata_q, exp);
    endtask : rd
    task automatic t_pc;
        chk(pc_q, 16'h0000);
        pc_jump_addr = 13'h1FFF;
        pc_jump = 1'b1;
        @(negedge clk);
        pc_jump = 1'b0;
        chk(pc_q, 16'h0FFF);
        pc_step = 1'b1;
        @(negedge clk);
        chk(pc_q, 16'h0000);
        pc_jump = 1'b1;
        irq_take = 1'b1;
        @(negedge clk);
        irq_take = 1'b0;
        pc_jump = 1'b0;
        chk(pc_q, 16'h0004);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        pc_step = 1'b0;
        chk(pc_q, 16'h0000);
    endtask : t_pc
    task automatic t_bank;
        for (int b = 0; b < 4; b++) begin
            acc(1'b1, 7'h03, 8'(b << 5));
            chk(status_q, 16'(b << 5));
            acc(1'b1, 7'h30, 8'(8'h50 + b));
            chk(data_addr_q, 16'(b * 128 + 8'h30));
            chk(data_sfr_q, 16'h0000);
        end
        for (int b = 3; b >= 0; b--) begin
            acc(1'b1, 7'h03, 8'(b << 5));
            chk(data_sfr_q, 16'h0001);
            rd(7'h30, 8'(8'h50 + b));
        end
    endtask : t_bank
    task automatic t_map;
        acc(1'b1, 7'h03, 8'h40);
        acc(1'b1, 7'h04, 8'hA0);
        chk(file_select_pointer_q, 16'h00A0);
        acc(1'b1, 7'h75, 8'hC3);
        acc(1'b1, 7'h03, 8'h20);
        rd(7'h04, 8'hA0);
        acc(1'b1, 7'h00, 8'h5A);
        chk(data_addr_q, 16'h00A0);
        rd(7'h20, 8'h5A);
        acc(1'b1, 7'h03, 8'h00);
        rd(7'h75, 8'hC3);
        rd(7'h00, 8'h5A);
    endtask : t_map
    // Computed jump through the low pc byte, from bank 3
    task automatic t_pcl;
        acc(1'b1, 7'h03, 8'h60);
        acc(1'b1, 7'h0A, 8'h1F);
        rd(7'h0A, 8'h1F);
        acc(1'b1, 7'h02, 8'h34);
        chk(pc_q, 16'h0F34);
        rd(7'h02, 8'h34);
        rd(7'h01, 8'h00);
        acc(1'b1, 7'h04, 8'h80);
        acc(1'b1, 7'h00, 8'hFF);
        rd(7'h00, 8'h00);
        rd(7'h04, 8'h80);
        idle;
    endtask : t_pcl
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    initial begin
        {rst, pc_step, pc_jump, irq_take, data_req, data_we} = 6'h20;
        {pc_jump_addr, data_offset, data_wdata, prog_rdata} = 42'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_pc;
        t_bank;
        t_map;
        t_pcl;
        results;
    end
    // Watchdog: the whole run is far shorter than this bound
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        results;
    end
endmodule : mmb_memory_map_tb
bind mmb_memory_map mmb_chk #(.FLASH_ADDR_W(FLASH_ADDR_W)) i_mmb_chk (
    .clk, .rst, .pc_step, .pc_jump, .pc_jump_addr, .irq_take, .data_req,
    .data_offset, .pc_q, .data_addr_q, .data_sfr_q, .data_valid_q,
    .status_q, .file_select_pointer_q);
`default_nettype wire
